/* logic/vecarb_pkg.sv */
// Purpose: Constants shared by the vectored interrupt arbiter
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package vecarb_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_IRQ_EN_LOW = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN_HIGH = 8'h04;
  localparam logic [7:0] OFF_PRIO0 = 8'h08;
  localparam logic [7:0] OFF_PRIO5 = 8'h1C;
  localparam logic [7:0] OFF_SOFT_REQ = 8'h20;
  localparam logic [7:0] OFF_SOFT_EN = 8'h24;
  localparam logic [7:0] OFF_INT_STATUS = 8'h28;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h2C;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h30;
  localparam logic [7:0] OFF_ARB_STATE = 8'h34;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PRIO_LO_POS = 0;
  localparam int PRIO_HI_POS = 4;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [2:0] PRIO_RESET = 3'h0;
  localparam int STS_EVENT_TAKEN = 0;
  localparam int STS_EXC_TAKEN = 1;
  localparam int STS_BITS = 2;
  // ----------------------------------------------------------------
  // Source counts
  // ----------------------------------------------------------------
  localparam int NUM_EVENTS = 9;
  localparam int NUM_SOFT = 7;
  localparam int NUM_MASKABLE = 16;
  localparam int NUM_HW_EXC = 6;
  // ----------------------------------------------------------------
  // Vector layout (byte addresses of four-byte slots)
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_EXC_BASE = 16'h0000;
  localparam logic [15:0] VEC_TRAP_BASE = 16'h0040;
  localparam logic [15:0] VEC_TIMER_BASE = 16'h0080;
  localparam logic [15:0] VEC_UART_BASE = 16'h00A0;
  localparam logic [15:0] VEC_SOFT_BASE = 16'h0100;
  localparam int NUM_TIMER_EXT = 5;
endpackage

/* logic/vecarb_top.sv */
// Purpose: Vectored interrupt arbiter with APB register access
// Assumes: Request flags come from logic on i_clk; core acks vectors
// Notes: Exceptions and traps outrank every maskable source
`timescale 1ns/10ps
module vecarb_top #(
  parameter int P_ADDR_W = 8 // APB address width
) (
  input wire logic i_clk, // 50 MHz clock
  input wire logic i_srst, // Synchronous reset, active high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [P_ADDR_W-1:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic i_ext_irq0_flag, // External 0 request
  input wire logic i_timer0_overflow_flag, // Timer 0 request
  input wire logic i_ext_irq1_flag, // External 1 request
  input wire logic i_timer1_overflow_flag, // Timer 1 request
  input wire logic i_timer2_overflow_flag, // Timer 2 overflow
  input wire logic i_timer2_external_flag, // Timer 2 external
  input wire logic i_uart0_rx_flag, // UART0 receive
  input wire logic i_uart0_tx_flag, // UART0 transmit
  input wire logic i_uart1_rx_flag, // UART1 receive
  input wire logic i_uart1_tx_flag, // UART1 transmit
  input wire logic [5:0] i_exc_req, // Reset, bkpt, trace, stk, div0, return_from_irq
  input wire logic i_trap_req, // Trap instruction request
  input wire logic [3:0] i_trap_num, // Trap number
  input wire logic [3:0] i_core_prio, // Core execution priority
  input wire logic i_irq_ack, // Core takes presented vector
  output logic o_irq_req, // Vector request to core
  output logic [15:0] o_irq_vector, // Vector slot address
  output logic [3:0] o_irq_prio, // Priority of presented request
  output logic o_irq_exc, // Presented request is exception/trap
  output logic o_int // Summary interrupt, level
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (P_ADDR_W < 8) begin : g_chk
    $error("vecarb_top: P_ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] en_low_r;
  logic [7:0] en_high_r;
  logic [2:0] prio_r [vecarb_pkg::NUM_EVENTS];
  logic [6:0] soft_req_r;
  logic [6:0] soft_en_r;
  logic [vecarb_pkg::STS_BITS-1:0] sts_r;
  logic [vecarb_pkg::STS_BITS-1:0] sts_nxt;
  logic [vecarb_pkg::STS_BITS-1:0] ien_r;
  logic [31:0] rdata_r;
  logic req_r;
  logic [15:0] vec_r;
  logic [3:0] oprio_r;
  logic exc_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] addr;
  logic setup;
  logic wr_acc;
  logic prio_hit;
  logic [2:0] prio_idx;
  logic mapped;
  assign addr = i_paddr[7:0];
  assign setup = i_psel & ~i_penable;
  assign wr_acc = i_psel & i_penable & i_pwrite & mapped;
  assign prio_hit = (addr >= vecarb_pkg::OFF_PRIO0) &&
                    (addr <= vecarb_pkg::OFF_PRIO5) && (addr[1:0] == 2'b00);
  assign prio_idx = 3'(addr - vecarb_pkg::OFF_PRIO0 >> 2);
  assign mapped = ((i_paddr >> 8) == '0) && (prio_hit ||
    addr == vecarb_pkg::OFF_IRQ_EN_LOW || addr == vecarb_pkg::OFF_IRQ_EN_HIGH ||
    addr == vecarb_pkg::OFF_SOFT_REQ || addr == vecarb_pkg::OFF_SOFT_EN ||
    addr == vecarb_pkg::OFF_INT_STATUS || addr == vecarb_pkg::OFF_INT_CLEAR ||
    addr == vecarb_pkg::OFF_INT_ENABLE || addr == vecarb_pkg::OFF_ARB_STATE);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // ----------------------------------------------------------------
  // Request vector and effective priorities
  // ----------------------------------------------------------------
  logic [vecarb_pkg::NUM_EVENTS-1:0] ev_flag;
  logic [vecarb_pkg::NUM_EVENTS-1:0] ev_en;
  logic global_event_enable;
  logic [vecarb_pkg::NUM_MASKABLE-1:0] mreq;
  logic [3:0] mprio [vecarb_pkg::NUM_MASKABLE];
  logic [15:0] mvec [vecarb_pkg::NUM_MASKABLE];
  assign global_event_enable = en_low_r[vecarb_pkg::GLOBAL_EN_BIT];
  // Flags in arbitration rank order, timer 2 is OR of both flags
  assign ev_flag = {i_uart1_tx_flag, i_uart1_rx_flag, i_uart0_tx_flag,
                    i_uart0_rx_flag,
                    i_timer2_overflow_flag | i_timer2_external_flag,
                    i_timer1_overflow_flag, i_ext_irq1_flag,
                    i_timer0_overflow_flag, i_ext_irq0_flag};
  assign ev_en = {en_high_r[3:0], en_low_r[4:0]};

  // Per-source request, priority and vector
  for (genvar g = 0; g < vecarb_pkg::NUM_MASKABLE; g++) begin : g_src
    if (g < vecarb_pkg::NUM_EVENTS) begin : g_ev
      // Gated by own and global enable
      assign mreq[g] = ev_flag[g] & ev_en[g] & global_event_enable;
      // Nonzero field gets top bit set
      assign mprio[g] = (prio_r[g] == 3'h0) ? 4'h0 : {1'b1, prio_r[g]};
      if (g < vecarb_pkg::NUM_TIMER_EXT) begin : g_te
        assign mvec[g] = vecarb_pkg::VEC_TIMER_BASE + 16'(4 * g);
      end else begin : g_ua
        assign mvec[g] = vecarb_pkg::VEC_UART_BASE +
          16'(4 * (g - vecarb_pkg::NUM_TIMER_EXT));
      end
    end else begin : g_sw
      localparam int N = g - vecarb_pkg::NUM_EVENTS;
      // Software request n+1 has fixed priority n+1
      assign mreq[g] = soft_req_r[N] & soft_en_r[N];
      assign mprio[g] = 4'(N + 1);
      assign mvec[g] = vecarb_pkg::VEC_SOFT_BASE + 16'(4 * N);
    end
  end

  // ----------------------------------------------------------------
  // Maskable arbitration: highest priority, lowest rank on ties
  // ----------------------------------------------------------------
  logic win_valid;
  logic [3:0] win_prio;
  logic [15:0] win_vec;
  always_comb begin
    win_valid = 1'b0;
    win_prio = 4'h0;
    win_vec = 16'h0000;
    for (int k = 0; k < vecarb_pkg::NUM_MASKABLE; k++) begin
      // Strict compare keeps the lower rank on equal priority
      if (mreq[k] && mprio[k] != 4'h0 &&
          (!win_valid || mprio[k] > win_prio)) begin
        win_valid = 1'b1;
        win_prio = mprio[k];
        win_vec = mvec[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Exception and trap selection, no enable gating
  // ----------------------------------------------------------------
  logic exc_valid;
  logic [15:0] exc_vec;
  always_comb begin
    exc_valid = 1'b0;
    exc_vec = 16'h0000;
    if (i_trap_req) begin
      exc_valid = 1'b1;
      exc_vec = vecarb_pkg::VEC_TRAP_BASE + {10'h000, i_trap_num, 2'b00};
    end
    // Reset first, then hardware traps in order
    for (int k = vecarb_pkg::NUM_HW_EXC - 1; k >= 0; k--) begin
      if (i_exc_req[k]) begin
        exc_valid = 1'b1;
        exc_vec = vecarb_pkg::VEC_EXC_BASE + 16'(4 * k);
      end
    end
  end

  // Presented request: exceptions first, events above core priority
  logic mask_ok;
  logic pick_req;
  assign mask_ok = win_valid && (win_prio > i_core_prio);
  assign pick_req = exc_valid | mask_ok;

  // ----------------------------------------------------------------
  // Vector output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      req_r <= 1'b0;
      vec_r <= 16'h0000;
      oprio_r <= 4'h0;
      exc_r <= 1'b0;
    end else begin
      req_r <= pick_req;
      vec_r <= exc_valid ? exc_vec : (mask_ok ? win_vec : 16'h0000);
      oprio_r <= exc_valid ? 4'hF : (mask_ok ? win_prio : 4'h0);
      exc_r <= exc_valid;
    end
  end
  assign o_irq_req = req_r;
  assign o_irq_vector = vec_r;
  assign o_irq_prio = oprio_r;
  assign o_irq_exc = exc_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      en_low_r <= vecarb_pkg::EN_RESET;
      en_high_r <= vecarb_pkg::EN_RESET;
      soft_req_r <= 7'h00;
      soft_en_r <= 7'h00;
    end else if (wr_acc) begin
      if (addr == vecarb_pkg::OFF_IRQ_EN_LOW) begin
        en_low_r <= i_pwdata[7:0] & 8'h9F;
      end
      if (addr == vecarb_pkg::OFF_IRQ_EN_HIGH) begin
        en_high_r <= {4'h0, i_pwdata[3:0]};
      end
      if (addr == vecarb_pkg::OFF_SOFT_REQ) begin
        soft_req_r <= i_pwdata[6:0];
      end
      if (addr == vecarb_pkg::OFF_SOFT_EN) begin
        soft_en_r <= i_pwdata[6:0];
      end
    end
  end

  // Priority fields, three bits kept per source
  logic [3:0] prio_reg_of [vecarb_pkg::NUM_EVENTS];
  logic [vecarb_pkg::NUM_EVENTS-1:0] prio_hi_of;
  assign prio_reg_of = '{4'd0, 4'd0, 4'd1, 4'd1, 4'd2,
                         4'd4, 4'd4, 4'd5, 4'd5};
  assign prio_hi_of = 9'b1_0100_1010;
  for (genvar p = 0; p < vecarb_pkg::NUM_EVENTS; p++) begin : g_prio
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        prio_r[p] <= vecarb_pkg::PRIO_RESET;
      end else if (wr_acc && prio_hit && prio_idx == prio_reg_of[p][2:0]) begin
        prio_r[p] <= prio_hi_of[p] ?
          i_pwdata[vecarb_pkg::PRIO_HI_POS +: 3] :
          i_pwdata[vecarb_pkg::PRIO_LO_POS +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over clear
  // ----------------------------------------------------------------
  logic [vecarb_pkg::STS_BITS-1:0] sts_set;
  logic [vecarb_pkg::STS_BITS-1:0] sts_clr;
  assign sts_set[vecarb_pkg::STS_EVENT_TAKEN] = i_irq_ack & req_r & ~exc_r;
  assign sts_set[vecarb_pkg::STS_EXC_TAKEN] = i_irq_ack & req_r & exc_r;
  assign sts_clr = (wr_acc && addr == vecarb_pkg::OFF_INT_CLEAR) ?
                   i_pwdata[vecarb_pkg::STS_BITS-1:0] : '0;
  assign sts_nxt = (sts_r & ~sts_clr) | sts_set;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sts_r <= '0;
      ien_r <= '0;
    end else begin
      sts_r <= sts_nxt;
      if (wr_acc && addr == vecarb_pkg::OFF_INT_ENABLE) begin
        ien_r <= i_pwdata[vecarb_pkg::STS_BITS-1:0];
      end
    end
  end
  assign o_int = |(sts_r & ien_r);

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [7:0] prio_word;
  logic [31:0] rd_mux;
  assign prio_word =
    (prio_idx == 3'd0) ? {1'b0, prio_r[1], 1'b0, prio_r[0]} :
    (prio_idx == 3'd1) ? {1'b0, prio_r[3], 1'b0, prio_r[2]} :
    (prio_idx == 3'd2) ? {5'h00, prio_r[4]} :
    (prio_idx == 3'd4) ? {1'b0, prio_r[6], 1'b0, prio_r[5]} :
    (prio_idx == 3'd5) ? {1'b0, prio_r[8], 1'b0, prio_r[7]} : 8'h00;
  assign rd_mux =
    (addr == vecarb_pkg::OFF_IRQ_EN_LOW) ? {24'h00_0000, en_low_r} :
    (addr == vecarb_pkg::OFF_IRQ_EN_HIGH) ? {24'h00_0000, en_high_r} :
    prio_hit ? {24'h00_0000, prio_word} :
    (addr == vecarb_pkg::OFF_SOFT_REQ) ? {25'h000_0000, soft_req_r} :
    (addr == vecarb_pkg::OFF_SOFT_EN) ? {25'h000_0000, soft_en_r} :
    (addr == vecarb_pkg::OFF_INT_STATUS) ? {30'h0000_0000, sts_r} :
    (addr == vecarb_pkg::OFF_INT_ENABLE) ? {30'h0000_0000, ien_r} :
    (addr == vecarb_pkg::OFF_ARB_STATE) ?
      {9'h000, exc_r, req_r, oprio_r, vec_r, 1'b0} : 32'h0000_0000;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup) begin
      rdata_r <= (mapped && !i_pwrite) ? rd_mux : 32'h0000_0000;
    end
  end
  assign o_prdata = rdata_r;

endmodule // vecarb_top

/* sim/vecarb_assertions.sv */
// Purpose: Port assertions for the vectored interrupt arbiter
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to vecarb_top from the bench top file
`timescale 1ns/10ps
module vecarb_assertions #(
  parameter int P_ADDR_W = 8 // APB address width
) (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic [P_ADDR_W-1:0] i_paddr, // APB address
  input wire logic [31:0] o_prdata, // Read data
  input wire logic o_pready, // Ready
  input wire logic o_pslverr, // Error
  input wire logic [5:0] i_exc_req, // Exceptions
  input wire logic i_trap_req, // Trap request
  input wire logic [3:0] i_trap_num, // Trap number
  input wire logic [3:0] i_core_prio, // Core priority
  input wire logic o_irq_req, // Request to core
  input wire logic [15:0] o_irq_vector, // Vector
  input wire logic [3:0] o_irq_prio, // Priority
  input wire logic o_irq_exc // Exception flag
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Slot of the lowest pending exception
  function automatic logic [15:0] low_vec(input logic [5:0] r);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 5; i >= 0; i--) if (r[i]) v = 16'(4 * i);
    return v;
  endfunction
  sequence s_access;
    i_psel && i_penable;
  endsequence
  sequence s_exc;
    i_exc_req != 6'h00;
  endsequence
  sequence s_trap_only;
    i_trap_req && i_exc_req == 6'h00;
  endsequence
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  AST_READY: assert property (s_access |-> o_pready)
    else $error("ready low in access phase");
  AST_UNMAPPED: assert property (s_access and i_paddr > 8'h34 |->
    o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  AST_EXC_VEC: assert property (s_exc |=> o_irq_req && o_irq_exc &&
    o_irq_vector == low_vec($past(i_exc_req)))
    else $error("exception vector wrong");
  AST_TRAP_VEC: assert property (s_trap_only |=> o_irq_exc &&
    o_irq_vector == 16'h0040 + {10'h000, $past(i_trap_num), 2'b00})
    else $error("trap vector wrong");
  AST_EXC_PRIO: assert property (o_irq_exc |->
    o_irq_req && o_irq_prio == 4'hF)
    else $error("exception not presented at top priority");
  AST_EV_PRIO: assert property (o_irq_req && !o_irq_exc &&
    o_irq_vector < 16'h0100 |-> o_irq_prio inside {[4'h9:4'hF]})
    else $error("event effective priority wrong");
  AST_SOFT_PRIO: assert property (o_irq_req && !o_irq_exc &&
    o_irq_vector >= 16'h0100 |-> o_irq_prio == {1'b0, o_irq_vector[4:2]} + 4'h1)
    else $error("software priority wrong");
  AST_ABOVE_CORE: assert property (o_irq_req && !o_irq_exc |->
    o_irq_prio > $past(i_core_prio))
    else $error("request not above core priority");
endmodule // vecarb_assertions

/* sim/vecarb_core_model.sv */
// Purpose: Core side model that acknowledges presented vectors
// Assumes: Acks are one-cycle pulses on i_clk
// Notes: Acks only while the bench allows it
`timescale 1ns/10ps
module vecarb_core_model (
  input wire logic i_clk, // Clock
  input wire logic i_srst, // Reset
  input wire logic i_irq_req, // Presented request
  input wire logic i_ack_on, // Bench allows acks
  output logic o_irq_ack // Ack pulse
);
  // A pulse every other cycle while a request is presented, never two in a row
  always_ff @(posedge i_clk) begin
    o_irq_ack <= !i_srst && i_ack_on && i_irq_req && !o_irq_ack;
  end
endmodule // vecarb_core_model

/* sim/tb_vecarb_top.sv */
// Purpose: Self-checking bench for the vectored interrupt arbiter
// Assumes: Zero-wait APB slave, one cycle vector latency
// Notes: Registers, vectors, ties, masks and status are exercised
`timescale 1ns/10ps
module tb_vecarb_top;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [9:0] flags = 10'h000;
  logic [5:0] i_exc_req = 6'h00;
  logic i_trap_req = 1'b0;
  logic [3:0] i_trap_num = 4'h0;
  logic [3:0] i_core_prio = 4'h0;
  logic ack_on = 1'b0;
  logic i_irq_ack;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_irq_req, o_irq_exc, o_int;
  logic [15:0] o_irq_vector;
  logic [3:0] o_irq_prio;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] wa [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28};
  logic [7:0] wx [8] = '{8'h9F, 8'h0F, 8'h77, 8'h07, 8'h00, 8'h7F, 8'h7F, 8'h00};
  // --------------------------------------------------------------
  // Clock, design, core model, timeout
  // --------------------------------------------------------------
  always #10 i_clk = ~i_clk;
  vecarb_top #(.P_ADDR_W(8)) dut (.i_clk(i_clk), .i_srst(i_srst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_irq0_flag(flags[0]), .i_timer0_overflow_flag(flags[1]),
    .i_ext_irq1_flag(flags[2]), .i_timer1_overflow_flag(flags[3]),
    .i_timer2_overflow_flag(flags[4]), .i_timer2_external_flag(flags[5]),
    .i_uart0_rx_flag(flags[6]), .i_uart0_tx_flag(flags[7]),
    .i_uart1_rx_flag(flags[8]), .i_uart1_tx_flag(flags[9]),
    .i_exc_req(i_exc_req), .i_trap_req(i_trap_req), .i_trap_num(i_trap_num),
    .i_core_prio(i_core_prio), .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req),
    .o_irq_vector(o_irq_vector), .o_irq_prio(o_irq_prio),
    .o_irq_exc(o_irq_exc), .o_int(o_int));
  vecarb_core_model core (.i_clk(i_clk), .i_srst(i_srst),
    .i_irq_req(o_irq_req), .i_ack_on(ack_on), .o_irq_ack(i_irq_ack));
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    @(posedge i_clk);
    while (o_pready !== 1'b1) @(posedge i_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // Expected {req, exc, prio, vector} after the one-cycle latency
  task automatic irq_is(input logic [21:0] exp);
    repeat (2) @(posedge i_clk);
    #1;
    chk({10'h000, o_irq_req, o_irq_exc, o_irq_prio, o_irq_vector}, {10'h000, exp});
    @(posedge i_clk);
  endtask
  function automatic logic [15:0] ev_vec(input int i);
    if (i < 5) return 16'h0080 + 16'(4 * i);
    if (i == 5) return 16'h0090;
    return 16'h00A0 + 16'(4 * (i - 6));
  endfunction
  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    for (int a = 0; a < 'h38; a += 4) rdc(8'(a), 32'h0000_0000);
    rdc(8'h38, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    foreach (wa[k]) begin
      apb(1'b1, wa[k], 32'hFFFF_FFFF);
      rdc(wa[k], {24'h00_0000, wx[k]});
    end
    // Software interrupts one at a time, then gated off
    for (int n = 1; n < 8; n++) begin
      apb(1'b1, 8'h20, 32'(1) << (n - 1));
      irq_is({2'b10, 4'(n), 16'h0100 + 16'(4 * (n - 1))});
    end
    apb(1'b1, 8'h24, 32'h0000_0000);
    irq_is(22'h00_0000);
    apb(1'b1, 8'h20, 32'h0000_0000);
    // Every event flag alone at field 1
    for (int a = 8; a < 'h20; a += 4) apb(1'b1, 8'(a), 32'h0000_0011);
    for (int i = 0; i < 10; i++) begin
      flags <= 10'(1) << i;
      irq_is({2'b10, 4'h9, ev_vec(i)});
    end
    // Timer 2 field sits in the low nibble of its register
    flags <= 10'h030;
    apb(1'b1, 8'h10, 32'h0000_0072);
    rdc(8'h10, 32'h0000_0002);
    irq_is({2'b10, 4'hA, 16'h0090});
    apb(1'b1, 8'h10, 32'h0000_0011);
    flags <= 10'h3FF;
    irq_is({2'b10, 4'h9, 16'h0080});
    apb(1'b1, 8'h08, 32'h0000_0010);
    irq_is({2'b10, 4'h9, 16'h0084});
    apb(1'b1, 8'h1C, 32'h0000_0070);
    irq_is({2'b10, 4'hF, 16'h00AC});
    i_core_prio <= 4'hF;
    irq_is(22'h00_0000);
    i_core_prio <= 4'hE;
    irq_is({2'b10, 4'hF, 16'h00AC});
    i_core_prio <= 4'h0;
    apb(1'b1, 8'h00, 32'h0000_001F);
    irq_is(22'h00_0000);
    apb(1'b1, 8'h00, 32'h0000_0080);
    apb(1'b1, 8'h04, 32'h0000_0000);
    irq_is(22'h00_0000);
    // Exceptions and traps while every source enable is off, global enable still on
    for (int b = 0; b < 6; b++) begin
      i_exc_req <= 6'(1) << b;
      irq_is({2'b11, 4'hF, 16'(4 * b)});
    end
    i_exc_req <= 6'h00;
    i_trap_req <= 1'b1;
    for (int n = 0; n < 16; n++) begin
      i_trap_num <= 4'(n);
      irq_is({2'b11, 4'hF, 16'h0040 + 16'(4 * n)});
    end
    rdc(8'h34, 32'h007E_00F8);
    // Status, enable and clear of the summary interrupt
    ack_on <= 1'b1;
    repeat (3) @(posedge i_clk);
    ack_on <= 1'b0;
    @(posedge i_clk);
    rdc(8'h28, 32'h0000_0002);
    chk(32'(o_int), 32'h0000_0000);
    apb(1'b1, 8'h30, 32'h0000_0003);
    chk(32'(o_int), 32'h0000_0001);
    apb(1'b1, 8'h2C, 32'h0000_0002);
    chk(32'(o_int), 32'h0000_0000);
    rdc(8'h28, 32'h0000_0000);
    // Second reset clears the configuration
    i_trap_req <= 1'b0;
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rdc(8'h00, 32'h0000_0000);
    irq_is(22'h00_0000);
    print_verdict();
  end
endmodule // tb_vecarb_top
bind vecarb_top vecarb_assertions #(.P_ADDR_W(P_ADDR_W)) u_chk (
  .i_clk(i_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_exc_req(i_exc_req), .i_trap_req(i_trap_req),
  .i_trap_num(i_trap_num), .i_core_prio(i_core_prio),
  .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
  .o_irq_prio(o_irq_prio), .o_irq_exc(o_irq_exc));
